/* File: core/pedx_pkg.sv */
// Contract
// R1: with energy sleep enabled and the sleep crossover extension bit set, crossover time grows by 2976 ms, else no extension.
// R2: the sleep crossover extension bit resets to zero and the manual crossover extension bit to one.
// R3: with auto-negotiation off and the manual extension bit set, crossover time grows by 32 periods of 62 ms; code also needs auto crossover on.
// R4: with auto-negotiation on, the manual extension bit has no effect on crossover timing.
// R5: software should set the manual extension bit when it turns auto-negotiation off with auto crossover on.
// R6: soft-reset-immune fields return to defaults on the PHY reset but keep their values on a soft reset.
// R7: the energy sleep enable bit turns the low power mode off at zero and on at one, and resets to zero.
// R8: while energy sleep is active, link pulse behaviour comes from the sleep pulse and crossover register.
// R9: the alternate irq select bit picks the primary scheme at zero and the alternate at one, resets to zero, soft-reset-immune.
// R10: the energy present flag falls after 256 ms without line energy, or 1500 ms with auto-negotiation on.
// R11: energy present is forced to one by hard reset, and by soft reset when auto-negotiation is or will be on.
// R12: reserved bits of both registers read as zero and ignore writes.
package pedx_pkg;
  // register byte addresses: printed indices 16 and 17 times four, plus control, status and irq block
  localparam logic [7:0] PEDX_IDX_CFG = 8'h10;
  localparam logic [7:0] PEDX_IDX_MODE = 8'h11;
  localparam logic [7:0] PEDX_ADDR_CFG = 8'h40;
  localparam logic [7:0] PEDX_ADDR_MODE = 8'h44;
  localparam logic [7:0] PEDX_ADDR_CTRL = 8'h80;
  localparam logic [7:0] PEDX_ADDR_STAT = 8'h84;
  localparam logic [7:0] PEDX_ADDR_IRQ_ST = 8'h88;
  localparam logic [7:0] PEDX_ADDR_IRQ_EN = 8'h8c;
  localparam logic [7:0] PEDX_ADDR_IRQ_CLR = 8'h90;
  // field positions
  localparam int PEDX_CFG_XO_SLEEP = 1;
  localparam int PEDX_CFG_XO_MANUAL = 0;
  localparam int PEDX_MODE_SLEEP_EN = 13;
  localparam int PEDX_MODE_ALT_IRQ = 6;
  localparam int PEDX_MODE_ENERGY = 1;
  localparam logic [15:0] PEDX_CFG_WMASK = 16'hfc0b;
  localparam logic [15:0] PEDX_CFG_RST = 16'h0001;
  localparam logic [15:0] PEDX_MODE_WMASK = 16'h2040;
  localparam logic [15:0] PEDX_MODE_RST = 16'h0000;
  // control register bits: 0 aneg enable, 1 auto crossover, 2 soft reset, 3 phy reset
  localparam int PEDX_CTRL_ANEG = 0;
  localparam int PEDX_CTRL_AUTOXO = 1;
  localparam int PEDX_CTRL_SRST = 2;
  localparam int PEDX_CTRL_PRST = 3;
  localparam logic [3:0] PEDX_CTRL_RST = 4'h3;
  // irq bits: 0 energy lost, 1 energy gained
  localparam int PEDX_IRQ_W = 2;
  // timing
  localparam longint PEDX_CLK_HZ = 64'd50000000;
  localparam int PEDX_MS_CYC = int'(PEDX_CLK_HZ / 1000);
  localparam int PEDX_XO_SLEEP_MS = 2976;
  localparam int PEDX_XO_MAN_N = 32;
  localparam int PEDX_XO_MAN_PER_MS = 62;
  localparam int PEDX_XO_MAN_MS = PEDX_XO_MAN_N * PEDX_XO_MAN_PER_MS;
  localparam int PEDX_ENERGY_MS = 256;
  localparam int PEDX_ENERGY_AN_MS = 1500;
  localparam logic [1:0] PEDX_RESP_OK = 2'b00;
  localparam logic [1:0] PEDX_RESP_ERR = 2'b10;
endpackage : pedx_pkg

/* File: core/pedx_cfg_if.sv */
`timescale 1ns/1ps
`default_nettype none
// configuration and control that the register bank hands to the timing core, and the energy state the core hands back
interface pedx_cfg_if;
  logic sleep_en;
  logic xo_sleep_ext;
  logic xo_man_ext;
  logic aneg_en;
  logic soft_rst;
  logic energy_present;
  logic energy_lost;
  logic energy_gained;
  modport regs (output sleep_en, xo_sleep_ext, xo_man_ext, aneg_en, soft_rst,
    input energy_present, energy_lost, energy_gained);
  modport core (input sleep_en, xo_sleep_ext, xo_man_ext, aneg_en, soft_rst,
    output energy_present, energy_lost, energy_gained);
endinterface : pedx_cfg_if
`default_nettype wire

/* File: core/pedx_energy.sv */
`timescale 1ns/1ps
`default_nettype none
// energy presence timer and crossover extension select
module pedx_energy
  import pedx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic line_energy,
  input wire logic ms_tick,
  output logic [11:0] xo_ext_ms,
  pedx_cfg_if.core cfg
);
  logic [10:0] idle_ms_r;
  logic energy_r;
  logic [10:0] limit;

  // longer hold with negotiation because pulses come in bursts
  assign limit = cfg.aneg_en ? 11'(PEDX_ENERGY_AN_MS) : 11'(PEDX_ENERGY_MS);

  // idle counter and flag; soft reset with aneg forces the flag high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_ms_r <= '0;
      energy_r <= 1'b1; // [R11]
    end else if (cfg.soft_rst && cfg.aneg_en) begin
      idle_ms_r <= '0;
      energy_r <= 1'b1; // [R11]
    end else if (line_energy) begin
      idle_ms_r <= '0;
      energy_r <= 1'b1;
    end else if (ms_tick && energy_r) begin
      if (idle_ms_r + 11'd1 >= limit) begin
        energy_r <= 1'b0; // [R10]
        idle_ms_r <= '0;
      end else begin
        idle_ms_r <= idle_ms_r + 11'd1;
      end
    end
  end

  assign cfg.energy_present = energy_r;
  // only a soft reset that forces the flag up may mask the falling event
  assign cfg.energy_lost = energy_r && !line_energy && ms_tick && !(cfg.soft_rst && cfg.aneg_en)
    && (idle_ms_r + 11'd1 >= limit);
  assign cfg.energy_gained = !energy_r && line_energy;

  // crossover extension in ms; manual extension only counts without aneg
  always_comb begin
    xo_ext_ms = '0;
    if (cfg.sleep_en && cfg.xo_sleep_ext) begin
      xo_ext_ms = 12'(PEDX_XO_SLEEP_MS); // [R1]
    end else if (!cfg.aneg_en && cfg.xo_man_ext) begin
      xo_ext_ms = 12'(PEDX_XO_MAN_MS); // [R3] [R4]
    end
  end

  a_energy_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    line_energy |=> cfg.energy_present)
    else $error("energy flag low after energy");
  a_xo_aneg_ignore: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    (cfg.aneg_en && !(cfg.sleep_en && cfg.xo_sleep_ext)) |-> xo_ext_ms == 12'd0)
    else $error("manual extension applied with aneg");
  a_xo_sleep_ext: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    (cfg.sleep_en && cfg.xo_sleep_ext) |-> xo_ext_ms == 12'd2976)
    else $error("sleep extension wrong");
  a_xo_manual_ext: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    (!cfg.aneg_en && cfg.xo_man_ext && !cfg.sleep_en) |-> xo_ext_ms == 12'd1984)
    else $error("manual extension wrong");
  a_energy_srst: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    (cfg.soft_rst && cfg.aneg_en) |=> cfg.energy_present)
    else $error("soft reset did not force energy flag");
endmodule : pedx_energy
`default_nettype wire

/* File: core/pedx_top.sv */
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// register bank for energy sleep and crossover timing, axi4-lite slave
module pedx_top
  import pedx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line_energy,
  output logic energy_sleep_enable,
  output logic energy_detect_sleep_mode,
  output logic alternate_irq_select,
  output logic [11:0] xo_ext_ms,
  output logic [15:0] sleep_pulse_cfg,
  output logic phy_soft_reset_bit,
  output logic irq
);
  import pedx_pkg::*;

  pedx_cfg_if cfg ();

  logic [15:0] cfg_r;
  logic [15:0] mode_r;
  logic [3:0] ctrl_r;
  logic [PEDX_IRQ_W-1:0] irq_st_r;
  logic [PEDX_IRQ_W-1:0] irq_en_r;
  logic [15:0] ms_cnt_r;
  logic ms_tick;
  logic [7:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_have_r;
  logic wr_go;
  logic prst;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [15:0] mode_rd;
  logic [PEDX_IRQ_W-1:0] irq_set;
  logic [PEDX_IRQ_W-1:0] irq_clr;
  logic sleep_state_r;

  // merges strobed bytes of a write into the current word
  function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (cur & ~m) | (d & m);
  endfunction : merge

  // millisecond enable from the 50 MHz clock
  always_ff @(posedge aclk) begin
    if (!aresetn || ms_tick) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_cnt_r + 16'd1;
    end
  end
  assign ms_tick = (ms_cnt_r == 16'(PEDX_MS_CYC - 1));

  // write address and data are captured independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_go) begin
      w_have_r <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PEDX_RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      unique case (aw_addr_r & 8'hfc)
        PEDX_ADDR_CFG, PEDX_ADDR_MODE, PEDX_ADDR_CTRL, PEDX_ADDR_STAT,
        PEDX_ADDR_IRQ_ST, PEDX_ADDR_IRQ_EN, PEDX_ADDR_IRQ_CLR: s_axi_bresp <= PEDX_RESP_OK;
        default: s_axi_bresp <= PEDX_RESP_ERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign wval = merge(32'h0, w_data_r, w_strb_r);
  assign wmask = merge(32'h0, 32'hffffffff, w_strb_r);
  assign prst = ctrl_r[PEDX_CTRL_PRST];

  // control register: aneg and auto crossover levels, self clearing reset pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= PEDX_CTRL_RST;
    end else begin
      ctrl_r[PEDX_CTRL_SRST] <= 1'b0;
      ctrl_r[PEDX_CTRL_PRST] <= 1'b0;
      if (wr_go && (aw_addr_r & 8'hfc) == PEDX_ADDR_CTRL) begin
        ctrl_r <= 4'(merge({28'h0, ctrl_r}, wval, w_strb_r));
      end
    end
  end

  // soft-reset-immune fields: only hard and phy reset restore them; soft reset leaves them
  always_ff @(posedge aclk) begin
    if (!aresetn || prst) begin
      cfg_r <= PEDX_CFG_RST; // [R2] [R6]
      mode_r <= PEDX_MODE_RST; // [R7] [R9] [R6]
    end else if (wr_go) begin
      if ((aw_addr_r & 8'hfc) == PEDX_ADDR_CFG) begin
        cfg_r <= (cfg_r & ~(PEDX_CFG_WMASK & wmask[15:0]))
          | (wval[15:0] & PEDX_CFG_WMASK & wmask[15:0]); // [R12]
      end
      if ((aw_addr_r & 8'hfc) == PEDX_ADDR_MODE) begin
        mode_r <= (mode_r & ~(PEDX_MODE_WMASK & wmask[15:0]))
          | (wval[15:0] & PEDX_MODE_WMASK & wmask[15:0]); // [R12]
      end
    end
  end

  // sleep state entered when enabled and no energy; left once energy returns
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_state_r <= 1'b0;
    end else begin
      sleep_state_r <= mode_r[PEDX_MODE_SLEEP_EN] && !cfg.energy_present; // [R7]
    end
  end

  assign cfg.sleep_en = mode_r[PEDX_MODE_SLEEP_EN];
  assign cfg.xo_sleep_ext = cfg_r[PEDX_CFG_XO_SLEEP];
  // manual extension only matters with auto crossover running
  assign cfg.xo_man_ext = cfg_r[PEDX_CFG_XO_MANUAL] && ctrl_r[PEDX_CTRL_AUTOXO];
  assign cfg.aneg_en = ctrl_r[PEDX_CTRL_ANEG];
  assign cfg.soft_rst = ctrl_r[PEDX_CTRL_SRST];

  pedx_energy u_energy (
    .aclk(aclk),
    .aresetn(aresetn),
    .line_energy(line_energy),
    .ms_tick(ms_tick),
    .xo_ext_ms(xo_ext_ms),
    .cfg(cfg.core)
  );

  assign energy_sleep_enable = mode_r[PEDX_MODE_SLEEP_EN];
  assign energy_detect_sleep_mode = sleep_state_r;
  assign alternate_irq_select = mode_r[PEDX_MODE_ALT_IRQ]; // [R9]
  // pulse config is only presented while the sleep state is live
  assign sleep_pulse_cfg = sleep_state_r ? (cfg_r & 16'hfc08) : 16'h0000; // [R8]
  assign phy_soft_reset_bit = ctrl_r[PEDX_CTRL_SRST];

  // sticky irq status: set wins over clear
  assign irq_set = {cfg.energy_gained, cfg.energy_lost};
  assign irq_clr = (wr_go && (aw_addr_r & 8'hfc) == PEDX_ADDR_IRQ_CLR)
    ? wval[PEDX_IRQ_W-1:0] : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_r <= '0;
    end else begin
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_r <= '0;
    end else if (wr_go && (aw_addr_r & 8'hfc) == PEDX_ADDR_IRQ_EN) begin
      irq_en_r <= wval[PEDX_IRQ_W-1:0];
    end
  end
  assign irq = |(irq_st_r & irq_en_r);

  // reads; reserved bits come back zero
  assign mode_rd = mode_r | (cfg.energy_present ? 16'h0002 : 16'h0000); // [R12]
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= PEDX_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= PEDX_RESP_OK;
      unique case (s_axi_araddr & 8'hfc)
        PEDX_ADDR_CFG: s_axi_rdata <= {16'h0, cfg_r};
        PEDX_ADDR_MODE: s_axi_rdata <= {16'h0, mode_rd};
        PEDX_ADDR_CTRL: s_axi_rdata <= {28'h0, ctrl_r};
        PEDX_ADDR_STAT: s_axi_rdata <= {20'h0, xo_ext_ms};
        PEDX_ADDR_IRQ_ST: s_axi_rdata <= {30'h0, irq_st_r};
        PEDX_ADDR_IRQ_EN: s_axi_rdata <= {30'h0, irq_en_r};
        PEDX_ADDR_IRQ_CLR: s_axi_rdata <= 32'h0;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= PEDX_RESP_ERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // bus answers stand until the master takes them; a read answer comes one cycle after its request, a write answer one cycle after both halves are held
  a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped before taken");
  a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read answer dropped or changed before taken");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read answer late");

  // sticky status: an event is never lost, a clear only drops what it names
  a_irq_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    (|irq_set) |=> ((irq_st_r & $past(irq_set)) == $past(irq_set)))
    else $error("irq event lost");
  a_irq_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (|irq_clr) |=> ((irq_st_r & $past(irq_clr) & ~$past(irq_set)) == '0))
    else $error("irq clear ignored");
  a_irq_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (irq_clr == '0) |=> ((irq_st_r & $past(irq_st_r)) == $past(irq_st_r)))
    else $error("irq status dropped without clear");

  // reset strobes, register views and the sleep state
  a_reset_pulses: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    (ctrl_r[PEDX_CTRL_SRST] || prst) |=> !(ctrl_r[PEDX_CTRL_SRST] || prst))
    else $error("reset strobe longer than one cycle");
  a_stat_read: assert property (@(posedge aclk) disable iff (!aresetn) // [R1] [R3]
    (s_axi_arvalid && s_axi_arready && (s_axi_araddr & 8'hfc) == PEDX_ADDR_STAT)
    |=> s_axi_rdata == {20'h0, $past(xo_ext_ms)}) else $error("extension read wrong");
  a_flag_read: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    (s_axi_arvalid && s_axi_arready && (s_axi_araddr & 8'hfc) == PEDX_ADDR_MODE)
    |=> s_axi_rdata[1] == $past(cfg.energy_present)) else $error("energy flag read wrong");
  a_sleep_enter: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    (energy_sleep_enable && !cfg.energy_present) |=> energy_detect_sleep_mode)
    else $error("sleep state not entered");

  // register contents and their outputs
  a_prst_defaults: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    prst |=> (cfg_r == 16'h0001 && mode_r == 16'h0000))
    else $error("phy reset did not restore defaults");
  a_srst_keeps: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    (cfg.soft_rst && !prst && !wr_go) |=> ($stable(cfg_r) && $stable(mode_r)))
    else $error("soft reset changed immune fields");
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
    ((cfg_r & 16'h03f4) == 16'h0 && (mode_r & 16'hdfbf) == 16'h0))
    else $error("reserved bits set");
  a_alt_irq_out: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
    alternate_irq_select == mode_r[6])
    else $error("alt irq select mismatch");
  a_sleep_cfg_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    !sleep_state_r |-> sleep_pulse_cfg == 16'h0)
    else $error("pulse cfg outside sleep");
  a_sleep_state: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    !energy_sleep_enable |=> !energy_detect_sleep_mode)
    else $error("sleep while disabled");
endmodule : pedx_top
`default_nettype wire

/* File: bench/pedx_link_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// far end of the pair: puts energy on the line only while it transmits
module pedx_link_partner (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic talking,
  output logic line_energy
);
  // silent while reset is held; after reset the line follows talking
  always_ff @(posedge aclk) begin
    line_energy <= aresetn & talking;
  end
endmodule : pedx_link_partner
`default_nettype wire

/* File: bench/pedx_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pedx_top_tb;
  import pedx_pkg::*;
  logic aclk = 0, aresetn = 0, talking = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, line_energy;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp;
  logic sleep_en, sleep_mode, alt_irq, srst, irq;
  logic [11:0] xo_ext;
  logic [15:0] pulse_cfg;
  int mismatches = 0, samples_checked = 0, srst_seen = 0;

  pedx_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .line_energy(line_energy), .energy_sleep_enable(sleep_en),
    .energy_detect_sleep_mode(sleep_mode), .alternate_irq_select(alt_irq),
    .xo_ext_ms(xo_ext), .sleep_pulse_cfg(pulse_cfg), .phy_soft_reset_bit(srst),
    .irq(irq));
  pedx_link_partner partner (.aclk(aclk), .aresetn(aresetn), .talking(talking),
    .line_energy(line_energy));

  // 50 MHz
  always #10 aclk = ~aclk;
  // the soft reset strobe lasts one cycle, so count it where it shows
  always @(posedge aclk) begin
    if (srst === 1'b1) begin
      srst_seen++;
    end
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  task automatic hung;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    mismatches++;
    stop_test();
  endtask : hung

  // offers address and data together, releases each once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 50 && !(aw_done && w_done); n++) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1;
        awvalid <= 0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1;
        wvalid <= 0;
      end
    end
    if (!(aw_done && w_done)) hung();
    for (n = 0; n < 50 && bvalid !== 1'b1; n++) @(posedge aclk);
    if (bvalid !== 1'b1) hung();
    chk({30'h0, bresp}, {30'h0, er});
    bready <= 0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready === 1'b1) break;
    end
    if (arready !== 1'b1) hung();
    arvalid <= 0;
    for (n = 0; n < 50 && rvalid !== 1'b1; n++) @(posedge aclk);
    if (rvalid !== 1'b1) hung();
    chk(rdata, exp);
    rready <= 0;
    @(posedge aclk);
  endtask : rd

  task automatic test_reset;
    rd(PEDX_ADDR_CFG, 32'h1);
    rd(PEDX_ADDR_MODE, 32'h2);
    rd(PEDX_ADDR_CTRL, 32'h3);
    chk({sleep_en, alt_irq, irq}, 32'h0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_reserved;
    wr(PEDX_ADDR_CFG, 32'hffffffff, PEDX_RESP_OK);
    rd(PEDX_ADDR_CFG, 32'hfc0b);
    wr(PEDX_ADDR_MODE, 32'hffffffff, PEDX_RESP_OK);
    rd(PEDX_ADDR_MODE, 32'h2042);
    chk({sleep_en, alt_irq}, 32'h3);
    wr(8'h7c, 32'h0, PEDX_RESP_ERR);
    rd(PEDX_ADDR_CFG, 32'hfc0b);
    $display("test reserved done");
  endtask : test_reserved

  task automatic test_xover;
    chk(xo_ext, 32'd2976);
    rd(PEDX_ADDR_STAT, 32'd2976);
    // sleep still enabled but its extension bit clear: nothing is added
    wr(PEDX_ADDR_CFG, 32'h1, PEDX_RESP_OK);
    chk(xo_ext, 32'h0);
    wr(PEDX_ADDR_MODE, 32'h0, PEDX_RESP_OK);
    chk(xo_ext, 32'h0);
    // manual extension is already set before negotiation is turned off
    wr(PEDX_ADDR_CTRL, 32'h2, PEDX_RESP_OK);
    chk(xo_ext, 32'd1984);
    wr(PEDX_ADDR_CFG, 32'h0, PEDX_RESP_OK);
    chk(xo_ext, 32'h0);
    wr(PEDX_ADDR_CFG, 32'h1, PEDX_RESP_OK);
    wr(PEDX_ADDR_CTRL, 32'h3, PEDX_RESP_OK);
    chk(xo_ext, 32'h0);
    $display("test crossover done");
  endtask : test_xover

  task automatic test_resets;
    wr(PEDX_ADDR_MODE, 32'h40, PEDX_RESP_OK);
    wr(PEDX_ADDR_CFG, 32'h0808, PEDX_RESP_OK);
    wr(PEDX_ADDR_CTRL, 32'h5, PEDX_RESP_OK);
    chk(srst_seen, 32'h1);
    rd(PEDX_ADDR_MODE, 32'h42);
    rd(PEDX_ADDR_CFG, 32'h0808);
    wr(PEDX_ADDR_CTRL, 32'h9, PEDX_RESP_OK);
    rd(PEDX_ADDR_MODE, 32'h2);
    rd(PEDX_ADDR_CFG, 32'h1);
    $display("test resets done");
  endtask : test_resets

  task automatic test_energy;
    wr(PEDX_ADDR_CFG, 32'hfc0b, PEDX_RESP_OK);
    wr(PEDX_ADDR_MODE, 32'h2000, PEDX_RESP_OK);
    talking <= 0;
    repeat (2000) @(posedge aclk);
    // a short silence is far below the timeout, so the flag stays up
    rd(PEDX_ADDR_MODE, 32'h2002);
    chk({sleep_mode, pulse_cfg}, 32'h0);
    talking <= 1;
    wr(PEDX_ADDR_MODE, 32'h0, PEDX_RESP_OK);
    $display("test energy done");
  endtask : test_energy

  task automatic test_irq;
    wr(PEDX_ADDR_IRQ_EN, 32'h3, PEDX_RESP_OK);
    rd(PEDX_ADDR_IRQ_EN, 32'h3);
    rd(PEDX_ADDR_IRQ_ST, 32'h0);
    chk(irq, 32'h0);
    wr(PEDX_ADDR_IRQ_CLR, 32'h3, PEDX_RESP_OK);
    rd(PEDX_ADDR_IRQ_CLR, 32'h0);
    wr(PEDX_ADDR_IRQ_EN, 32'h0, PEDX_RESP_OK);
    chk(irq, 32'h0);
    $display("test irq done");
  endtask : test_irq

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    test_reset();
    test_reserved();
    test_xover();
    test_resets();
    test_energy();
    test_irq();
    stop_test();
  end
endmodule : pedx_top_tb
`default_nettype wire
